// ---- design/pci_power_mgmt_csr.v ----
// Power-management control/status and extension registers in config space
// Contract
// RL1 - Wake flag sets on every wake event, whatever the enable says.
// RL2 - Writing one to the wake flag clears it and drops the wake output.
// RL3 - Writing zero to the wake flag changes nothing.
// RL4 - Wake enable gates the wake output.
// RL5 - Wake enable resets to zero without cold-state wake support.
// RL6 - With cold-state wake support the enable survives reset; software clears it. Here only COLD_WAKE, not WAKE_SUPPORT[4] alone, keeps it.
// RL7 - With no wake support advertised the enable reads zero, read-only.
// RL8 - Dynamic info select bits 14-9 read zero.
// RL9 - Dynamic info flag bit 4 reads zero.
// RL10 - Reserved bits 7-5 and 3-2 read zero; writes ignored.
// RL11 - Power level field bits 1-0: 00 D0, 10 D2, 11 D3hot.
// RL12 - Code 01 (light sleep) is unsupported and not entered.
// RL13 - Register survives the internal reset on D3hot to D0.
// RL14 - Extension register is read-only zero.
// RL15 - Power report value bits 15-8 read 00h.
// RL16 - Bridge extension field bits 7-0 read 00h.
// RL17 - Capability light-sleep bit reads zero.
// RL18 - Wake output is flag AND enable, registered on the core clock.
`timescale 1ns/10ps
`include "pm_csr_defs.vh"
module pci_power_mgmt_csr #(
   parameter COLD_WAKE = 1'b0,
   parameter [4:0] WAKE_SUPPORT = 5'h0c
) (
   CORE_CLK,
   RST_B,
   FUNC_RST_B,
   CFG_ADDR,
   CFG_WR,
   CFG_RD,
   CFG_BE,
   CFG_WDATA,
   WAKE_EVENT,
   CFG_RDATA,
   POWER_LEVEL,
   WAKE_OUT
);
   input  wire        CORE_CLK;
   input  wire        RST_B;
   input  wire        FUNC_RST_B;
   input  wire [7:0]  CFG_ADDR;
   input  wire        CFG_WR;
   input  wire        CFG_RD;
   input  wire [1:0]  CFG_BE;
   input  wire [15:0] CFG_WDATA;
   input  wire        WAKE_EVENT;
   output reg  [15:0] CFG_RDATA;
   output reg  [1:0]  POWER_LEVEL;
   output reg         WAKE_OUT;

   // ************************************
   // State and next-state values
   // ************************************
   reg         flag_q;
   reg         flag_d;
   reg         en_q;
   reg         en_d;
   reg  [1:0]  lvl_q;
   reg  [1:0]  lvl_d;
   reg         wake_d;
   reg  [15:0] rdata_d;

   // ************************************
   // Internal reset input
   // ************************************
   // Internal D3hot-to-D0 reset: deliberately unused
   // Registers must survive it
   // RL13

   // ************************************
   // Address and byte-lane decode
   // ************************************
   wire        cs_hit;
   wire        ext_hit;
   wire        cap_hit;
   wire        cs_wr;
   wire        wr_lo;
   wire        wr_hi;

   assign cs_hit  = (CFG_ADDR == `PMCS_OFFSET);
   assign ext_hit = (CFG_ADDR == `PMEXT_OFFSET);
   assign cap_hit = (CFG_ADDR == `CAP_OFFSET);
   assign cs_wr   = CFG_WR & cs_hit;
   assign wr_lo   = cs_wr & CFG_BE[`BE_LO];
   assign wr_hi   = cs_wr & CFG_BE[`BE_HI];

   // ************************************
   // Write data fields
   // ************************************
   wire        wr_flag_bit;
   wire        wr_en_bit;
   wire [1:0]  wr_lvl_code;
   wire        clr_req;
   wire        lvl_legal;
   wire        lvl_req;

   assign wr_flag_bit = CFG_WDATA[`WAKE_FLAG_BIT];
   assign wr_en_bit   = CFG_WDATA[`WAKE_EN_BIT];
   assign wr_lvl_code = CFG_WDATA[`PWR_HI_BIT:`PWR_LO_BIT];
   assign clr_req     = wr_hi & wr_flag_bit; // RL2 RL3
   assign lvl_legal   = (wr_lvl_code != `LVL_D1); // RL12
   assign lvl_req     = wr_lo & lvl_legal;

   // ************************************
   // Advertised wake support
   // ************************************
   wire        sup_cold;
   wire [3:0]  sup_states;
   wire [4:0]  sup_field;
   wire        wake_capable;

   assign sup_cold     = (COLD_WAKE != 0) | WAKE_SUPPORT[4];
   assign sup_states   = WAKE_SUPPORT[3:0];
   assign sup_field    = {sup_cold, sup_states};
   assign wake_capable = (sup_field != `SUP_NONE); // RL7

   // ************************************
   // Control/status word
   // ************************************
   wire [5:0]  dyn_sel_field;
   wire        dyn_flag_field;
   wire [2:0]  rsvd_hi_field;
   wire [1:0]  rsvd_lo_field;
   wire [15:0] cs_word;

   assign dyn_sel_field  = `DYN_SEL_VALUE; // RL8
   assign dyn_flag_field = `DYN_FLAG_VALUE; // RL9
   assign rsvd_hi_field  = `RSVD_HI_VALUE; // RL10
   assign rsvd_lo_field  = `RSVD_LO_VALUE; // RL10
   assign cs_word        = {flag_q,
                            dyn_sel_field,
                            en_q,
                            rsvd_hi_field,
                            dyn_flag_field,
                            rsvd_lo_field,
                            lvl_q};

   // ************************************
   // Capability word
   // ************************************
   wire        light_sleep_bit;
   wire        d2_bit;
   wire [8:0]  cap_low_field;
   wire [15:0] cap_word;

   assign light_sleep_bit = `LIGHT_SLEEP_CAP; // RL17
   assign d2_bit          = `D2_CAPABLE;
   assign cap_low_field   = `CAP_LOW_VALUE;
   assign cap_word        = {sup_field,
                             d2_bit,
                             light_sleep_bit,
                             cap_low_field};

   // ************************************
   // Extension word
   // ************************************
   // Fixed fields only, no storage
   wire [7:0]  power_report_field;
   wire [7:0]  bridge_ext_field;
   wire [15:0] ext_word;

   assign power_report_field = `POWER_REPORT_VAL; // RL15
   assign bridge_ext_field   = `BRIDGE_EXT_VAL; // RL16
   assign ext_word           = {power_report_field, bridge_ext_field}; // RL14

   // ************************************
   // Wake flag next state
   // ************************************
   // Set wins over a clear in the same cycle
   always @* begin
      flag_d = flag_q;
      if (clr_req)
         flag_d = 1'h0; // RL2
      if (WAKE_EVENT)
         flag_d = 1'h1; // RL1
   end

   // ************************************
   // Wake enable next state
   // ************************************
   always @* begin
      en_d = en_q;
      if (wr_hi)
         en_d = wr_en_bit & wake_capable; // RL7
   end

   // ************************************
   // Power level next state
   // ************************************
   // Code 01 keeps the old level
   always @* begin
      lvl_d = lvl_q;
      if (lvl_req) begin
         case (wr_lvl_code)
            `LVL_D0:    lvl_d = `LVL_D0; // RL11
            `LVL_D2:    lvl_d = `LVL_D2;
            `LVL_D3HOT: lvl_d = `LVL_D3HOT;
            default:    lvl_d = lvl_q; // RL12
         endcase
      end
   end

   // ************************************
   // Wake output next state
   // ************************************
   always @* begin
      wake_d = flag_d & en_d; // RL4 RL18
   end

   // ************************************
   // Read mux
   // ************************************
   // Zero when no read is taken
   always @* begin
      rdata_d = `WORD_ZERO;
      if (CFG_RD) begin
         if (cs_hit)
            rdata_d = cs_word;
         else if (ext_hit)
            rdata_d = ext_word; // RL14
         else if (cap_hit)
            rdata_d = cap_word; // RL17
         else
            rdata_d = `WORD_ZERO;
      end
   end

   // ************************************
   // Wake flag register
   // ************************************
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         flag_q <= `FLAG_RESET;
      end else begin
         flag_q <= flag_d; // RL3 RL13
      end
   end

   // ************************************
   // Wake enable register
   // ************************************
   generate
      if (COLD_WAKE != 0) begin : g_sticky
         // No reset: kept across resets, software clears it at load
         always @(posedge CORE_CLK) begin
            en_q <= en_d; // RL6
         end
      end else begin : g_cleared
         always @(posedge CORE_CLK or negedge RST_B) begin
            if (!RST_B) begin
               en_q <= `EN_RESET; // RL5
            end else begin
               en_q <= en_d; // RL13
            end
         end
      end
   endgenerate

   // ************************************
   // Power level register
   // ************************************
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         lvl_q <= `LVL_D0;
      end else begin
         lvl_q <= lvl_d; // RL11 RL13
      end
   end

   // ************************************
   // Read data output
   // ************************************
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         CFG_RDATA <= `WORD_ZERO;
      end else begin
         CFG_RDATA <= rdata_d;
      end
   end

   // ************************************
   // Power level output
   // ************************************
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         POWER_LEVEL <= `LVL_D0;
      end else begin
         POWER_LEVEL <= lvl_d;
      end
   end

   // ************************************
   // Wake output
   // ************************************
   always @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         WAKE_OUT <= `FLAG_RESET;
      end else begin
         WAKE_OUT <= wake_d; // RL18
      end
   end
endmodule

// ---- pkg/pm_csr_defs.vh ----
// Offsets, field positions and codes of the power-management config registers
`ifndef PM_CSR_DEFS_VH
`define PM_CSR_DEFS_VH
`define PMCS_OFFSET      8'h48
`define PMEXT_OFFSET     8'h4a
`define CAP_OFFSET       8'h46
`define WAKE_FLAG_BIT    15
`define WAKE_EN_BIT      8
`define PWR_LO_BIT       0
`define PWR_HI_BIT       1
`define LIGHT_SLEEP_BIT  9
`define LVL_D0           2'h0
`define LVL_D1           2'h1
`define LVL_D2           2'h2
`define LVL_D3HOT        2'h3
`define PMCS_RESET       16'h0000
`define PMEXT_VALUE      16'h0000
`define BE_LO            0
`define BE_HI            1
`define SUP_NONE         5'h00
`define DYN_SEL_VALUE    6'h00
`define DYN_FLAG_VALUE   1'h0
`define RSVD_HI_VALUE    3'h0
`define RSVD_LO_VALUE    2'h0
`define LIGHT_SLEEP_CAP  1'h0
`define D2_CAPABLE       1'h1
`define CAP_LOW_VALUE    9'h001
`define POWER_REPORT_VAL 8'h00
`define BRIDGE_EXT_VAL   8'h00
`define WORD_ZERO        16'h0000
`define FLAG_RESET       1'h0
`define EN_RESET         1'h0
`endif

// ---- verification/wake_src.sv ----
// Wake event source on the link side
`timescale 1ns/10ps
module wake_src(input clk, input fire, output reg ev);
   initial ev = 0;
   always @(posedge clk) ev <= fire;
endmodule

// ---- verification/pm_asserts.sv ----
// Port checker for the power-management registers
`timescale 1ns/10ps
module pm_chk(input CORE_CLK, RST_B, FUNC_RST_B, CFG_WR, CFG_RD, WAKE_EVENT, WAKE_OUT,
   input [7:0] CFG_ADDR, input [1:0] CFG_BE, POWER_LEVEL, input [15:0] CFG_WDATA, CFG_RDATA);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   sequence s_hi; CFG_WR && CFG_ADDR == 8'h48 && CFG_BE[1]; endsequence
   sequence s_cs_rd; CFG_RD && CFG_ADDR == 8'h48; endsequence
   property p_set; WAKE_EVENT ##1 s_cs_rd |=> CFG_RDATA[15]; endproperty
   property p_fall; $fell(WAKE_OUT) |-> $past(CFG_WR); endproperty
   property p_clr; s_hi ##0 (CFG_WDATA[15] && !WAKE_EVENT) |=> !WAKE_OUT; endproperty
   property p_keep; s_hi ##0 (CFG_WDATA[15:8] == 8'h01 && WAKE_OUT) |=> WAKE_OUT; endproperty
   property p_en; s_hi ##0 !CFG_WDATA[8] |=> !WAKE_OUT; endproperty
   property p_rise; $rose(WAKE_OUT) |-> $past(WAKE_EVENT || CFG_WR); endproperty
   property p_lvl; CFG_WR && CFG_ADDR == 8'h48 && CFG_BE[0] && CFG_WDATA[1:0] != 2'h1
      |=> POWER_LEVEL == $past(CFG_WDATA[1:0]); endproperty
   property p_no1; POWER_LEVEL != 2'h1; endproperty
   property p_hold; !CFG_WR |=> $stable(POWER_LEVEL); endproperty
   property p_ext; CFG_RD && CFG_ADDR == 8'h4a |=> CFG_RDATA == 16'h0000; endproperty
   property p_rsv; CFG_RD && CFG_ADDR == 8'h48 |=> (CFG_RDATA & 16'h7efc) == 16'h0000; endproperty
   a_clr: assert property (p_clr) else $error("clr");
   a_keep: assert property (p_keep) else $error("keep");
   a_en: assert property (p_en) else $error("en");
   a_rise: assert property (p_rise) else $error("rise");
   a_lvl: assert property (p_lvl) else $error("lvl");
   a_no1: assert property (p_no1) else $error("no1");
   a_hold: assert property (p_hold) else $error("hold");
   a_ext: assert property (p_ext) else $error("ext");
   a_rsv: assert property (p_rsv) else $error("rsv");
   a_set: assert property (p_set) else $error("set");
   a_fall: assert property (p_fall) else $error("fall");
endmodule
bind pci_power_mgmt_csr pm_chk pm_chk_inst(.CORE_CLK(CORE_CLK), .RST_B(RST_B),
   .FUNC_RST_B(FUNC_RST_B), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .WAKE_EVENT(WAKE_EVENT),
   .WAKE_OUT(WAKE_OUT), .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .POWER_LEVEL(POWER_LEVEL),
   .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA));

// ---- verification/pci_power_mgmt_csr_test.sv ----
// Testbench for the power-management registers
`timescale 1ns/10ps
module pci_power_mgmt_csr_test;
   reg clk = 0, rb = 0, fb = 1, w = 0, r = 0, fire = 0;
   reg [7:0] a = 0;
   reg [1:0] be = 0, lv;
   reg [15:0] d = 0;
   wire [15:0] q;
   wire [1:0] pl;
   wire ev, wo;
   integer errors = 0, comparisons = 0, cyc = 0, i;
   initial forever #5 clk = ~clk;
   wake_src wake_src_inst(.clk(clk), .fire(fire), .ev(ev));
   pci_power_mgmt_csr pci_power_mgmt_csr_inst(.CORE_CLK(clk), .RST_B(rb), .FUNC_RST_B(fb),
      .CFG_ADDR(a), .CFG_WR(w), .CFG_RD(r), .CFG_BE(be), .CFG_WDATA(d), .WAKE_EVENT(ev),
      .CFG_RDATA(q), .POWER_LEVEL(pl), .WAKE_OUT(wo));
   task complete_run; begin
      if (errors == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   end endtask
   task chk(input [15:0] g, e); begin
      comparisons = comparisons + 1;
      if (g !== e) begin errors = errors + 1; $display("BAD %0t got %h exp %h", $time, g, e); end
   end endtask
   task acc(input wn, input [7:0] ad, input [1:0] b, input [15:0] v); begin
      @(posedge clk) #1; w = wn; r = !wn; a = ad; be = b; d = v;
      @(posedge clk) #1; w = 0; r = 0;
   end endtask
   task pulse; begin
      @(posedge clk) #1 fire = 1; @(posedge clk) #1 fire = 0; @(posedge clk) #1;
   end endtask
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 400) begin errors = errors + 1; complete_run; end
   end
   initial begin
      #16 rb = 1;
      acc(0, 8'h48, 0, 0); chk(q, 16'h0000);
      acc(1, 8'h48, 2, 16'h0000);
      acc(0, 8'h46, 0, 0); chk(q, 16'h6401);
      acc(1, 8'h4a, 3, 16'hffff); acc(0, 8'h4a, 0, 0); chk(q, 16'h0000);
      acc(1, 8'h48, 3, 16'hffff); acc(0, 8'h48, 0, 0); chk(q, 16'h0103);
      lv = 2'h3;
      for (i = 0; i < 4; i = i + 1) begin
         acc(1, 8'h48, 1, i[15:0]); if (i != 1) lv = i[1:0]; chk({14'h0, pl}, {14'h0, lv});
      end
      pulse; chk({15'h0, wo}, 16'h1);
      acc(1, 8'h48, 2, 16'h0100); chk({15'h0, wo}, 16'h1);
      fb = 0; acc(0, 8'h48, 0, 0); fb = 1; chk(q, 16'h8103);
      fire = 1; acc(1, 8'h48, 2, 16'h8100); fire = 0;
      acc(0, 8'h48, 0, 0); chk(q, 16'h8103);
      acc(1, 8'h48, 2, 16'h8100); chk({15'h0, wo}, 16'h0);
      acc(1, 8'h48, 2, 0); pulse; chk({15'h0, wo}, 16'h0);
      acc(0, 8'h48, 0, 0); chk(q, 16'h8003);
      acc(1, 8'h48, 2, 16'h0100); chk({15'h0, wo}, 16'h1);
      @(posedge clk) #1 rb = 0;
      @(posedge clk) #1 rb = 1;
      acc(0, 8'h48, 0, 0); chk(q, 16'h0000); chk({15'h0, wo}, 16'h0);
      complete_run;
   end
endmodule
